/* rtl/aawd_defines.vh */
// Constants for the address area and width decoder
`ifndef AAWD_DEFINES_VH
`define AAWD_DEFINES_VH

// Address field positions
`define AAWD_WIDTH_BIT 27
`define AAWD_AREA_HI 26
`define AAWD_AREA_LO 24
`define AAWD_PERIPH_W_BIT 8
`define AAWD_A6_W_BIT 14
`define AAWD_EXT_ADDR_HI 27
`define AAWD_LOW_ADDR_HI 23

// Area codes
`define AAWD_AREA0 3'h0
`define AAWD_AREA1 3'h1
`define AAWD_AREA5 3'h5
`define AAWD_AREA6 3'h6
`define AAWD_AREA7 3'h7

// Boot mode patterns for area 0
`define AAWD_MODE_EXT8 3'h0
`define AAWD_MODE_EXT16 3'h1
`define AAWD_MODE_ROM 3'h2

// Target types
`define AAWD_TGT_EXT 3'h0
`define AAWD_TGT_ROM 3'h1
`define AAWD_TGT_DRAM 3'h2
`define AAWD_TGT_PERIPH 3'h3
`define AAWD_TGT_MUXIO 3'h4
`define AAWD_TGT_RAM 3'h5

// Bus width codes
`define AAWD_BW8 2'h0
`define AAWD_BW16 2'h1
`define AAWD_BW32 2'h2

// Access size codes
`define AAWD_SZ8 2'h0
`define AAWD_SZ16 2'h1
`define AAWD_SZ32 2'h2

// Beat counts per access
`define AAWD_BEATS_ONE 3'h1
`define AAWD_BEATS_TWO 3'h2
`define AAWD_BEATS_FOUR 3'h4

`endif

/* rtl/aawd_lane_steer.v */
// Byte lane steering of one bus beat onto the multiplexed address/data pins
`include "aawd_defines.vh"

module aawd_lane_steer (
    // Beat description
    input wire [1:0] bus_width,
    input wire [1:0] beat_size,
    input wire byte_odd,
    input wire [15:0] beat_data,
    // Pin drive
    output reg [15:0] pin_data,
    output reg [15:0] pin_oe
);
    always @* begin
        pin_data = 16'h0000;
        pin_oe = 16'h0000;
        if (bus_width == `AAWD_BW8 || beat_size == `AAWD_SZ8) begin
            if (bus_width != `AAWD_BW8 && !byte_odd) begin
                // Even byte rides the upper lane on a wide bus
                pin_data = {beat_data[7:0], 8'h00};
                pin_oe = 16'hFF00;
            end else begin
                pin_data = {8'h00, beat_data[7:0]};
                pin_oe = 16'h00FF;
            end
        end else begin
            pin_data = beat_data;
            pin_oe = 16'hFFFF;
        end
    end
endmodule // aawd_lane_steer

/* rtl/aawd_decoder.v */
// Address area, bus width and access splitting decoder
// How it works
// - The top four address bits are ignored and never reach any pin.
// - Address bit 27 picks 8-bit bus when zero, 16-bit when one.
// - Address bits 26 to 24 pick one of eight 16-Mbyte areas.
// - The three area bits decode to eight per-area chip selects.
// - Area 0 target follows boot mode pins: ext8, ext16 or 32-bit ROM.
// - Area 1 DRAM enable chooses external memory or DRAM with strobes.
// - Area 5 low half is peripherals, width by bit 8; high half ext16.
// - Area 6 low half width follows bit 14; high half is 16-bit.
// - Area 6 low half is external memory or multiplexed I/O space.
// - Area 7 is 32-bit RAM with bit 27 set, else ext8 memory.
// - 8-bit bus uses low pins only; 16-bit words use all sixteen.
// - Byte on 16-bit bus: even address high lane, odd address low lane.
// - Word to 8-bit or longword to 16-bit area takes two accesses.
// - Longword to an 8-bit area takes four accesses.
// - DRAM and multiplexed I/O areas get their own control strobes.
// - Chip selects are active low during the whole access, for external memory targets only; DRAM and multiplexed I/O get none.
// - Chip selects stay high for on-chip ROM, peripherals and RAM.
// - Area 1 is external memory when DRAM enable is 0, DRAM when 1.
// - Area 6 low half is multiplexed I/O when its enable is 1.
`include "aawd_defines.vh"

module aawd_decoder #(
    parameter ADDR_W = 32
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Boot straps and bus control bits
    input wire [2:0] boot_mode_pins,
    input wire dram_space_enable,
    input wire mux_io_space_enable,
    // Request from the CPU side
    input wire req_valid,
    input wire [ADDR_W-1:0] req_addr,
    input wire [1:0] req_size,
    input wire req_write,
    input wire [31:0] req_wdata,
    // Combinational decode of the presented address
    output wire [2:0] dec_area,
    output wire [2:0] dec_target,
    output wire [1:0] dec_width,
    output wire [2:0] dec_beats,
    // Sequencer status
    output reg busy_r,
    output reg done_r,
    // External beat
    output reg beat_valid_r,
    output reg [27:0] ext_addr_r,
    output reg [1:0] beat_size_r,
    output reg beat_write_r,
    output reg [7:0] area_select_n,
    output reg dram_strobe_r,
    output reg mux_io_strobe_r,
    output reg [15:0] addr_data_out_r,
    output reg [15:0] addr_data_oe_r
);
    // Sequencer states
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;

    // Straps sampled twice before use
    reg [2:0] mode_s1_r;
    reg [2:0] mode_s2_r;
    reg dram_s1_r;
    reg dram_s2_r;
    reg mio_s1_r;
    reg mio_s2_r;

    always @(posedge clk) begin
        if (!resetn) begin
            mode_s1_r <= 3'h0;
            mode_s2_r <= 3'h0;
            dram_s1_r <= 1'b0;
            dram_s2_r <= 1'b0;
            mio_s1_r <= 1'b0;
            mio_s2_r <= 1'b0;
        end else begin
            mode_s1_r <= boot_mode_pins;
            mode_s2_r <= mode_s1_r;
            dram_s1_r <= dram_space_enable;
            dram_s2_r <= dram_s1_r;
            mio_s1_r <= mux_io_space_enable;
            mio_s2_r <= mio_s1_r;
        end
    end

    // Address decode; bits above 27 are never looked at
    wire a27 = req_addr[`AAWD_WIDTH_BIT];
    wire [2:0] area = req_addr[`AAWD_AREA_HI:`AAWD_AREA_LO];
    reg [2:0] target;
    reg [1:0] width;
    reg [2:0] beats;

    always @* begin
        target = `AAWD_TGT_EXT;
        width = a27 ? `AAWD_BW16 : `AAWD_BW8;
        case (area)
            `AAWD_AREA0: begin
                case (mode_s2_r)
                    `AAWD_MODE_EXT16: width = `AAWD_BW16;
                    `AAWD_MODE_ROM: begin
                        target = `AAWD_TGT_ROM;
                        width = `AAWD_BW32;
                    end
                    default: width = `AAWD_BW8;
                endcase
            end
            `AAWD_AREA1: begin
                if (dram_s2_r)
                    target = `AAWD_TGT_DRAM;
            end
            `AAWD_AREA5: begin
                if (!a27) begin
                    target = `AAWD_TGT_PERIPH;
                    width = req_addr[`AAWD_PERIPH_W_BIT] ? `AAWD_BW16 : `AAWD_BW8;
                end
            end
            `AAWD_AREA6: begin
                if (!a27) begin
                    width = req_addr[`AAWD_A6_W_BIT] ? `AAWD_BW16 : `AAWD_BW8;
                    if (mio_s2_r)
                        target = `AAWD_TGT_MUXIO;
                end
            end
            `AAWD_AREA7: begin
                if (a27) begin
                    target = `AAWD_TGT_RAM;
                    width = `AAWD_BW32;
                end
            end
            default: target = `AAWD_TGT_EXT;
        endcase
        // Beats needed to carry the access over the chosen width
        beats = `AAWD_BEATS_ONE;
        if (req_size == `AAWD_SZ32 && width == `AAWD_BW8)
            beats = `AAWD_BEATS_FOUR;
        else if ((req_size == `AAWD_SZ16 && width == `AAWD_BW8) ||
                 (req_size == `AAWD_SZ32 && width == `AAWD_BW16))
            beats = `AAWD_BEATS_TWO;
    end

    assign dec_area = area;
    assign dec_target = target;
    assign dec_width = width;
    assign dec_beats = beats;

    // Captured access
    reg state_r;
    reg [2:0] cnt_r;
    reg [2:0] area_r;
    reg [2:0] target_r;
    reg [1:0] width_r;
    reg [1:0] size_r;
    reg write_r;
    reg [27:0] addr_r;
    reg [31:0] data_r;

    // Size and data of the beat now being issued
    wire [1:0] bsize = (width_r == `AAWD_BW8) ? `AAWD_SZ8 :
                       (width_r == `AAWD_BW16 && size_r == `AAWD_SZ32) ? `AAWD_SZ16 : size_r;
    wire [15:0] bdata = (bsize == `AAWD_SZ8) ? {8'h00, data_r[31:24]} : data_r[31:16];
    wire [2:0] bstep = (bsize == `AAWD_SZ8) ? 3'h1 : 3'h2;
    wire is_ext = (target_r == `AAWD_TGT_EXT);

    wire [15:0] lane_data;
    wire [15:0] lane_oe;

    aawd_lane_steer u_lane (
        .bus_width(width_r),
        .beat_size(bsize),
        .byte_odd(addr_r[0]),
        .beat_data(bdata),
        .pin_data(lane_data),
        .pin_oe(lane_oe)
    );

    always @(posedge clk) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            area_r <= 3'h0;
            target_r <= `AAWD_TGT_EXT;
            width_r <= `AAWD_BW8;
            size_r <= `AAWD_SZ8;
            write_r <= 1'b0;
            addr_r <= 28'h0000000;
            data_r <= 32'h00000000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (req_valid) begin
                        state_r <= ST_BUSY;
                        cnt_r <= beats;
                        area_r <= area;
                        target_r <= target;
                        width_r <= width;
                        size_r <= req_size;
                        write_r <= req_write;
                        addr_r <= req_addr[`AAWD_EXT_ADDR_HI:0];
                        // Left-justify so the lowest address byte goes first
                        data_r <= (req_size == `AAWD_SZ8) ? {req_wdata[7:0], 24'h000000} :
                                  (req_size == `AAWD_SZ16) ? {req_wdata[15:0], 16'h0000} :
                                  req_wdata;
                        busy_r <= 1'b1;
                    end
                end
                ST_BUSY: begin
                    // Consecutive beats step address and shift out data
                    addr_r <= addr_r + {25'h0000000, bstep};
                    data_r <= (bsize == `AAWD_SZ8) ? {data_r[23:0], 8'h00} :
                              {data_r[15:0], 16'h0000};
                    cnt_r <= cnt_r - `AAWD_BEATS_ONE;
                    if (cnt_r == `AAWD_BEATS_ONE) begin
                        state_r <= ST_IDLE;
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Registered pin-side outputs, one beat per clock while busy
    always @(posedge clk) begin
        if (!resetn) begin
            beat_valid_r <= 1'b0;
            ext_addr_r <= 28'h0000000;
            beat_size_r <= `AAWD_SZ8;
            beat_write_r <= 1'b0;
            area_select_n <= 8'hFF;
            dram_strobe_r <= 1'b0;
            mux_io_strobe_r <= 1'b0;
            addr_data_out_r <= 16'h0000;
            addr_data_oe_r <= 16'h0000;
        end else if (state_r == ST_BUSY) begin
            beat_valid_r <= 1'b1;
            ext_addr_r <= addr_r;
            beat_size_r <= bsize;
            beat_write_r <= write_r;
            area_select_n <= is_ext ? ~(8'h01 << area_r) : 8'hFF;
            dram_strobe_r <= (target_r == `AAWD_TGT_DRAM);
            mux_io_strobe_r <= (target_r == `AAWD_TGT_MUXIO);
            addr_data_out_r <= lane_data;
            addr_data_oe_r <= write_r ? lane_oe : 16'h0000;
        end else begin
            beat_valid_r <= 1'b0;
            ext_addr_r <= 28'h0000000;
            beat_size_r <= `AAWD_SZ8;
            beat_write_r <= 1'b0;
            area_select_n <= 8'hFF;
            dram_strobe_r <= 1'b0;
            mux_io_strobe_r <= 1'b0;
            addr_data_out_r <= 16'h0000;
            addr_data_oe_r <= 16'h0000;
        end
    end
endmodule // aawd_decoder

/* sim/aawd_decoder_props.sv */
// Concurrent checks on the decoder ports
`include "aawd_defines.vh"
module aawd_props #(
    parameter ADDR_W = 32
) (
    // Clock, reset and request
    input wire clk,
    input wire resetn,
    input wire req_valid,
    input wire [ADDR_W-1:0] req_addr,
    input wire [1:0] req_size,
    // Decode and beat outputs
    input wire [2:0] dec_area,
    input wire [2:0] dec_target,
    input wire [1:0] dec_width,
    input wire [2:0] dec_beats,
    input wire busy_r,
    input wire beat_valid_r,
    input wire beat_write_r,
    input wire [27:0] ext_addr_r,
    input wire [7:0] area_select_n,
    input wire [15:0] addr_data_oe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    wire [2:0] ra = req_addr[26:24];
    wire [2:0] ba = ext_addr_r[26:24];
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_area_code: assert property (dec_area == ra)
        else $error("area code mismatch");
    a_ext_width: assert property (ra inside {3'h2, 3'h3, 3'h4} |->
        dec_target == `AAWD_TGT_EXT && dec_width == (req_addr[27] ? `AAWD_BW16 : `AAWD_BW8))
        else $error("ext width");
    a_periph_width: assert property (ra == `AAWD_AREA5 && !req_addr[27] |->
        dec_target == `AAWD_TGT_PERIPH && dec_width == (req_addr[8] ? `AAWD_BW16 : `AAWD_BW8))
        else $error("periph width");
    a_ram_width: assert property (ra == `AAWD_AREA7 |->
        dec_width == (req_addr[27] ? `AAWD_BW32 : `AAWD_BW8)) else $error("area 7 width");
    a_four_beats: assert property (req_size == `AAWD_SZ32 && dec_width == `AAWD_BW8 |->
        dec_beats == 3'h4) else $error("beat count");
    a_two_beats: assert property (req_valid && !busy_r && dec_beats == 3'h2 |=>
        busy_r ##1 beat_valid_r [*2] ##1 !beat_valid_r) else $error("two beats");
    a_select_match: assert property (area_select_n != 8'hFF |-> beat_valid_r
        && area_select_n == ~(8'h01 << ba)) else $error("chip select");
    a_select_onchip: assert property (beat_valid_r && ba == `AAWD_AREA7 &&
        ext_addr_r[27] |-> area_select_n == 8'hFF) else $error("select on ram");
    a_read_release: assert property (beat_valid_r && !beat_write_r |->
        addr_data_oe_r == 16'h0000) else $error("read drive");
endmodule // aawd_props
bind aawd_decoder aawd_props #(.ADDR_W(ADDR_W)) u_props (.clk(clk), .resetn(resetn),
    .req_valid(req_valid), .req_addr(req_addr), .req_size(req_size), .dec_area(dec_area),
    .dec_target(dec_target), .dec_width(dec_width), .dec_beats(dec_beats), .busy_r(busy_r),
    .beat_valid_r(beat_valid_r), .beat_write_r(beat_write_r), .ext_addr_r(ext_addr_r),
    .area_select_n(area_select_n), .addr_data_oe_r(addr_data_oe_r));

/* sim/aawd_ext_mem.sv */
// Byte memory model on the far side, filled by write beats
module aawd_ext_mem (
    // Beat from the decoder
    input wire clk,
    input wire beat_valid_r,
    input wire beat_write_r,
    input wire [27:0] ext_addr_r,
    input wire [15:0] addr_data_out_r,
    input wire [15:0] addr_data_oe_r
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:15];
    wire [3:0] a = ext_addr_r[3:0];
    // Upper lane holds the lower address
    always @(posedge clk) begin
        if (beat_valid_r && beat_write_r) begin
            if (addr_data_oe_r[15])
                mem[a] <= addr_data_out_r[15:8];
            if (addr_data_oe_r == 16'h00FF)
                mem[a] <= addr_data_out_r[7:0];
            if (addr_data_oe_r == 16'hFFFF)
                mem[a + 4'h1] <= addr_data_out_r[7:0];
        end
    end
endmodule // aawd_ext_mem

/* sim/aawd_decoder_tb_top.sv */
// Self-checking bench for the address area and width decoder
`include "aawd_defines.vh"
module aawd_decoder_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, resetn = 1'b0, dram_en = 1'b0, mux_en = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] req_size = 2'h0;
    logic [31:0] req_addr = 32'h0, req_wdata = 32'h0;
    wire [2:0] dec_area, dec_target, dec_beats;
    wire [1:0] dec_width, beat_size_r;
    wire busy_r, done_r, beat_valid_r, beat_write_r, dram_strobe_r, mux_io_strobe_r;
    wire [27:0] ext_addr_r;
    wire [7:0] area_select_n;
    wire [15:0] addr_data_out_r, addr_data_oe_r;
    int n_fail = 0, tests_run = 0, nb, ncs, ndr, nmx, i;
    logic [27:0] fa = 28'h0000000;
    logic [15:0] loe = 16'h0000, ldat = 16'h0000;
    logic [1:0] lsz = 2'h0;
    always #5 clk = ~clk;
    aawd_decoder DUT (.clk(clk), .resetn(resetn), .boot_mode_pins(mode),
        .dram_space_enable(dram_en), .mux_io_space_enable(mux_en), .req_valid(req_valid),
        .req_addr(req_addr), .req_size(req_size), .req_write(req_write), .req_wdata(req_wdata),
        .dec_area(dec_area), .dec_target(dec_target), .dec_width(dec_width),
        .dec_beats(dec_beats), .busy_r(busy_r), .done_r(done_r), .beat_valid_r(beat_valid_r),
        .ext_addr_r(ext_addr_r), .beat_size_r(beat_size_r), .beat_write_r(beat_write_r),
        .area_select_n(area_select_n), .dram_strobe_r(dram_strobe_r),
        .mux_io_strobe_r(mux_io_strobe_r), .addr_data_out_r(addr_data_out_r),
        .addr_data_oe_r(addr_data_oe_r));
    aawd_ext_mem MEM (.clk(clk), .beat_valid_r(beat_valid_r), .beat_write_r(beat_write_r),
        .ext_addr_r(ext_addr_r), .addr_data_out_r(addr_data_out_r),
        .addr_data_oe_r(addr_data_oe_r));
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task dec(input logic [31:0] a, input logic [2:0] t, input logic [1:0] w);
        @(negedge clk);
        req_addr = a;
        #1;
        chk(dec_target, t);
        chk(dec_width, w);
    endtask
    // Issue one request and tally the beats until completion
    task req(input logic [31:0] a, input logic [1:0] s, input logic w, input logic [31:0] d);
        int k;
        @(negedge clk);
        req_valid = 1'b1;
        req_addr = a;
        req_size = s;
        req_write = w;
        req_wdata = d;
        @(negedge clk);
        req_valid = 1'b0;
        nb = 0;
        ncs = 0;
        ndr = 0;
        nmx = 0;
        fa = 28'h0000000;
        for (k = 0; k < 12 && done_r !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            nb += (beat_valid_r === 1'b1);
            ncs += (area_select_n !== 8'hFF);
            ndr += (dram_strobe_r === 1'b1);
            nmx += (mux_io_strobe_r === 1'b1);
            if (beat_valid_r === 1'b1) begin
                if (nb == 1)
                    fa = ext_addr_r;
                lsz = beat_size_r;
                loe = addr_data_oe_r;
                ldat = addr_data_out_r;
            end
        end
        if (done_r !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, done_r, 1'b1);
            complete_run;
        end
        // The far side stores the last beat one edge later
        @(posedge clk);
        #1;
    endtask
    task strap(input logic [2:0] m, input logic de, input logic me);
        @(negedge clk);
        mode = m;
        dram_en = de;
        mux_en = me;
        repeat (3) @(negedge clk);
    endtask
    task s_areas;
        for (i = 0; i < 8; i++) begin
            dec({5'h1E, i[2:0], 24'h0}, i == 5 ? 3'h3 : 3'h0, `AAWD_BW8);
            chk(dec_area, i);
            dec({5'h1F, i[2:0], 24'h0}, i == 7 ? 3'h5 : 3'h0,
                i == 0 ? `AAWD_BW8 : (i == 7 ? `AAWD_BW32 : `AAWD_BW16));
        end
        dec(32'h06004000, `AAWD_TGT_EXT, `AAWD_BW16);
    endtask
    task s_modes;
        for (i = 0; i < 8; i++) begin
            strap(i[2:0], 1'b0, 1'b0);
            dec(32'h0, i == 2 ? 3'h1 : 3'h0, i == 1 ? 2'h1 : (i == 2 ? 2'h2 : 2'h0));
        end
        strap(3'h0, 1'b0, 1'b0);
    endtask
    task s_split;
        req(32'hF2000004, `AAWD_SZ32, 1'b1, 32'h11223344);
        chk(nb, 4);
        chk(ncs, 4);
        chk(fa, 28'h2000004);
        chk(lsz, `AAWD_SZ8);
        chk(loe, 16'h00FF);
        chk(ldat, 16'h0044);
        chk({MEM.mem[4], MEM.mem[5], MEM.mem[6], MEM.mem[7]}, 32'h11223344);
        req(32'h0B000008, `AAWD_SZ32, 1'b1, 32'hA1B2C3D4);
        chk(nb, 2);
        chk(lsz, `AAWD_SZ16);
        chk(loe, 16'hFFFF);
        chk(ldat, 16'hC3D4);
        chk({MEM.mem[8], MEM.mem[9], MEM.mem[10], MEM.mem[11]}, 32'hA1B2C3D4);
        req(32'h0400000E, `AAWD_SZ16, 1'b1, 32'hE5F6);
        chk(nb, 2);
        chk({MEM.mem[14], MEM.mem[15]}, 16'hE5F6);
        req(32'h0A000002, `AAWD_SZ8, 1'b1, 32'h55);
        chk(loe, 16'hFF00);
        chk(ldat, 16'h5500);
        req(32'h0A000003, `AAWD_SZ8, 1'b1, 32'h66);
        chk(loe, 16'h00FF);
        chk(ldat, 16'h0066);
        chk({MEM.mem[2], MEM.mem[3]}, 16'h5566);
        req(32'h0A000002, `AAWD_SZ16, 1'b0, 32'h0);
        chk(nb, 1);
        chk(loe, 16'h0000);
    endtask
    task s_space;
        strap(3'h0, 1'b1, 1'b1);
        req(32'h01000000, `AAWD_SZ8, 1'b1, 32'h1);
        chk(ndr, 1);
        chk(ncs, 0);
        req(32'h06000000, `AAWD_SZ8, 1'b1, 32'h2);
        chk(nmx, 1);
        chk(ncs, 0);
        chk(dec_target, `AAWD_TGT_MUXIO);
        strap(3'h0, 1'b0, 1'b0);
        req(32'h01000000, `AAWD_SZ8, 1'b0, 32'h0);
        chk(ndr, 0);
        chk(ncs, 1);
        req(32'h06004000, `AAWD_SZ16, 1'b1, 32'h3);
        chk(nmx, 0);
        chk(ncs, 1);
        chk(nb, 1);
    endtask
    task s_onchip;
        req(32'h05000100, `AAWD_SZ16, 1'b1, 32'h1234);
        chk(ncs, 0);
        chk(nb, 1);
        req(32'h05000000, `AAWD_SZ8, 1'b0, 32'h0);
        chk(ncs, 0);
        req(32'h0F000000, `AAWD_SZ32, 1'b1, 32'h5);
        chk(ncs, 0);
        chk(nb, 1);
        strap(3'h2, 1'b0, 1'b0);
        req(32'h00000000, `AAWD_SZ32, 1'b0, 32'h0);
        chk(ncs, 0);
        chk(nb, 1);
        strap(3'h0, 1'b0, 1'b0);
    endtask
    initial begin
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        chk(area_select_n, 8'hFF);
        repeat (3) @(negedge clk);
        s_areas;
        s_modes;
        s_split;
        s_space;
        s_onchip;
        complete_run;
    end
endmodule // aawd_decoder_tb_top
